// [tgr_pkg.sv]
package tgr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_XCV_CTRL   = 6'h04;
    localparam logic [5:0] IDX_PAD_DRIVE  = 6'h05;
    localparam logic [5:0] IDX_AUX_LEVELS = 6'h07;
    localparam logic [5:0] IDX_CNT_A_STAT = 6'h08;
    localparam logic [5:0] IDX_CNT_B_STAT = 6'h09;
    localparam logic [5:0] IDX_CNT_C_STAT = 6'h0a;
    localparam logic [5:0] IDX_CNT_A_LOAD = 6'h0b;
    localparam logic [5:0] IDX_CNT_B_LOAD = 6'h0c;
    localparam logic [5:0] IDX_IRQ_STAT   = 6'h10;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h11;

    // Field positions
    localparam int unsigned XCV_MASK_LSB = 4;
    localparam int unsigned XCV_MASK_W   = 6;
    localparam int unsigned XCV_SKIP_BIT = 3;
    localparam int unsigned XCV_STEP_BIT = 2;
    localparam int unsigned XCV_RRX_BIT  = 1;
    localparam int unsigned XCV_INIT_BIT = 0;
    localparam int unsigned IRQ_STATE_BIT = 5;
    localparam int unsigned IRQ_CNT_LSB   = 11;
    localparam int unsigned IRQ_W         = 14;
    localparam int unsigned CNT_RUN_BIT   = 20;
    localparam int unsigned CNT_W         = 20;
    localparam int unsigned AUX_N         = 7;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Transceive control fields
    typedef struct packed {
        logic [5:0] state_mask;
        logic       skip_send;
        logic       per_byte_framing;
        logic       repeated_receive;
        logic       initiator;
    } tgr_xcv_t;

    // Counter status as seen by software
    typedef struct packed {
        logic        counter_active;
        logic [19:0] counter_live_value;
    } tgr_cnt_t;

    // Transceive states, in mask bit order
    typedef enum logic [2:0] {
        TGR_IDLE,
        TGR_PREPARE,
        TGR_TRANSMITTING,
        TGR_AWAIT_REPLY,
        TGR_AWAIT_FRAME,
        TGR_RECEIVING
    } tgr_state_t;

    // Word address match for one register index
    function automatic logic tgr_hit(input logic [7:0] a,
                                     input logic [5:0] idx);
        return a == {idx, 2'b00};
    endfunction : tgr_hit

endpackage : tgr_pkg

// [tgr_timer.sv]
`timescale 1ns/1ps
module tgr_timer #(
    parameter int unsigned W = 20
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] preload,
    // Status
    output logic              running,
    output logic [W-1:0]      value,
    output logic              expired
);

    logic         run_q;
    logic [W-1:0] val_q;
    logic         exp_q;

    // Down counter; start reloads and wins over stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            val_q <= '0;
            exp_q <= 1'b0;
        end else begin
            exp_q <= 1'b0;
            if (start) begin
                run_q <= 1'b1;
                val_q <= preload;
            end else if (stop) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                if (val_q == '0) begin
                    run_q <= 1'b0;
                    exp_q <= 1'b1;
                end else begin
                    val_q <= val_q - 1'b1;
                end
            end
        end
    end

    assign running = run_q;
    assign value   = val_q;
    assign expired = exp_q;

endmodule : tgr_timer

// [tgr_regs.sv]
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Functional notes
// (RULE1) Six state mask bits at 9:4
// (RULE2) Mask resets zero; zero mask never fires
// (RULE3) Mask bits map idle, prepare, transmit, reply, frame, receive
// (RULE4) Suppress bit blocks transmission start
// (RULE5) Suppress bit cleared entering await-reply
// (RULE6) Per-byte bit frames each byte separately
// (RULE7) Encoder pauses after byte until trigger
// (RULE8) Repeated receive rearms and stores status byte
// (RULE9) Frames stored word aligned, zero padded
// (RULE10) Bit 0 selects initiator operation
// (RULE11) Seven driver enables, reset zero
// (RULE12) Seven output levels, reset zero
// (RULE13) Counter status bit 20 shows running
// (RULE14) Counter status 19:0 shows live value
// (RULE15) Two 20-bit preload registers, reset zero
// (RULE16) State event in status bit 5, masked
// (RULE17) Writing one to bit 5 clears it
// (RULE18) Mask bit 1 selects the prepare state
module tgr_regs (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Transceive state machine
    input  wire tgr_pkg::tgr_state_t       xcv_state,
    input  wire logic                      send_request,
    input  wire logic                      guard_expired,
    input  wire logic                      tx_trigger,
    input  wire logic                      tx_byte_done,
    output logic                           tx_go,
    output logic                           encoder_hold,
    output logic                           per_byte_framing,
    output logic                           initiator,
    // Receive path
    input  wire logic                      rx_byte_valid,
    input  wire logic [7:0]                rx_byte,
    input  wire logic                      rx_end,
    input  wire logic [7:0]                rx_status,
    output logic                           rx_rearm,
    output logic                           mem_wr_valid,
    output logic [31:0]                    mem_wr_data,
    // Counters
    input  wire logic [2:0]                cnt_start,
    input  wire logic [2:0]                cnt_stop,
    input  wire logic [19:0]               cnt_c_preload,
    // General-purpose outputs
    output logic [6:0]                     aux_output_drive_en,
    output logic [6:0]                     aux_output_level,
    // Interrupt
    output logic                           irq
);
    import tgr_pkg::*;

    tgr_xcv_t              xcv_q;
    logic [31:0]           pad_q;
    logic [AUX_N-1:0]      lvl_q;
    logic [CNT_W-1:0]      load_a_q;
    logic [CNT_W-1:0]      load_b_q;
    logic [IRQ_W-1:0]      sts_q;
    logic [IRQ_W-1:0]      msk_q;
    logic [31:0]           prdata_q;
    tgr_state_t            prev_q;
    logic                  paused_q;
    logic [1:0]            lane_q;
    logic [31:0]           word_q;
    logic                  wr_valid_q;
    logic [31:0]           wr_data_q;
    logic                  stat_pend_q;
    logic [7:0]            stat_q;
    logic                  rearm_q;

    logic                  wr_en;
    logic                  rd_setup;
    logic                  mapped;
    logic                  entered;
    logic                  state_evt;
    logic [2:0]            cnt_run;
    logic [2:0]            cnt_exp;
    logic [CNT_W-1:0]      cnt_val [3];
    logic [CNT_W-1:0]      cnt_load [3];
    tgr_cnt_t              cnt_sts [3];
    logic [IRQ_W-1:0]      evt_vec;

    // Zero wait states; write lands at the access edge
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign mapped   = tgr_hit(paddr, IDX_XCV_CTRL)
                    | tgr_hit(paddr, IDX_PAD_DRIVE)
                    | tgr_hit(paddr, IDX_AUX_LEVELS)
                    | tgr_hit(paddr, IDX_CNT_A_STAT)
                    | tgr_hit(paddr, IDX_CNT_B_STAT)
                    | tgr_hit(paddr, IDX_CNT_C_STAT)
                    | tgr_hit(paddr, IDX_CNT_A_LOAD)
                    | tgr_hit(paddr, IDX_CNT_B_LOAD)
                    | tgr_hit(paddr, IDX_IRQ_STAT)
                    | tgr_hit(paddr, IDX_IRQ_MASK);
    assign pslverr  = psel & penable & ~mapped;

    // State entry detect; mask index equals state code
    assign entered   = xcv_state != prev_q;
    // (RULE1) independent state selects
    // (RULE3) bit order follows state order
    // (RULE18) bit 1 is the prepare state
    assign state_evt = entered & xcv_q.state_mask[xcv_state];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= TGR_IDLE;
        end else begin
            prev_q <= xcv_state;
        end
    end

    // Transceive control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // (RULE2) mask resets to zero
            xcv_q <= tgr_xcv_t'(RST_WORD[9:0]);
        end else begin
            if (wr_en && tgr_hit(paddr, IDX_XCV_CTRL)) begin
                xcv_q <= tgr_xcv_t'(pwdata[9:0]);
            end
            // (RULE5) hardware clear wins
            if (entered && xcv_state == TGR_AWAIT_REPLY) begin
                xcv_q.skip_send <= 1'b0;
            end
        end
    end

    // (RULE6) framing mode to the coder
    assign per_byte_framing = xcv_q.per_byte_framing;
    // (RULE10) initiator select
    assign initiator        = xcv_q.initiator;
    // (RULE4) suppress blocks the start
    assign tx_go = send_request & guard_expired & ~xcv_q.skip_send;

    // Pause after each byte; a byte done in the
    // trigger cycle still pauses so no byte runs on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            paused_q <= 1'b0;
        end else begin
            // (RULE7) hold until fresh trigger
            if (tx_byte_done && xcv_q.per_byte_framing) begin
                paused_q <= 1'b1;
            end else if (tx_trigger) begin
                paused_q <= 1'b0;
            end
        end
    end
    assign encoder_hold = paused_q;

    // Pad and level registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_q <= RST_WORD;
            lvl_q <= RST_WORD[AUX_N-1:0];
        end else begin
            if (wr_en && tgr_hit(paddr, IDX_PAD_DRIVE)) begin
                pad_q <= {24'h00_0000, pwdata[7:0]};
            end
            if (wr_en && tgr_hit(paddr, IDX_AUX_LEVELS)) begin
                lvl_q <= pwdata[AUX_N-1:0];
            end
        end
    end
    // (RULE11) driver enables
    assign aux_output_drive_en = pad_q[AUX_N-1:0];
    // (RULE12) driven levels
    assign aux_output_level    = lvl_q;

    // Preload registers; upper bits not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_a_q <= RST_WORD[CNT_W-1:0];
            load_b_q <= RST_WORD[CNT_W-1:0];
        end else begin
            // (RULE15) full 20-bit range
            if (wr_en && tgr_hit(paddr, IDX_CNT_A_LOAD)) begin
                load_a_q <= pwdata[CNT_W-1:0];
            end
            if (wr_en && tgr_hit(paddr, IDX_CNT_B_LOAD)) begin
                load_b_q <= pwdata[CNT_W-1:0];
            end
        end
    end

    assign cnt_load[0] = load_a_q;
    assign cnt_load[1] = load_b_q;
    assign cnt_load[2] = cnt_c_preload;

    // Three counters
    for (genvar i = 0; i < 3; i++) begin : g_cnt
        tgr_timer #(.W(CNT_W)) u_cnt (
            .pclk    (pclk),
            .presetn (presetn),
            .start   (cnt_start[i]),
            .stop    (cnt_stop[i]),
            .preload (cnt_load[i]),
            .running (cnt_run[i]),
            .value   (cnt_val[i]),
            .expired (cnt_exp[i])
        );
        // (RULE13) running flag
        // (RULE14) live value
        assign cnt_sts[i] = '{counter_active:     cnt_run[i],
                              counter_live_value: cnt_val[i]};
    end

    // Sticky events; set wins over a same-cycle clear
    always_comb begin
        evt_vec = '0;
        evt_vec[IRQ_STATE_BIT] = state_evt;
        evt_vec[IRQ_CNT_LSB +: 3] = cnt_exp;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= RST_WORD[IRQ_W-1:0];
            msk_q <= RST_WORD[IRQ_W-1:0];
        end else begin
            // (RULE16) record event
            // (RULE17) write one clears
            if (wr_en && tgr_hit(paddr, IDX_IRQ_STAT)) begin
                sts_q <= (sts_q & ~pwdata[IRQ_W-1:0]) | evt_vec;
            end else begin
                sts_q <= sts_q | evt_vec;
            end
            if (wr_en && tgr_hit(paddr, IDX_IRQ_MASK)) begin
                msk_q <= pwdata[IRQ_W-1:0];
            end
        end
    end
    // (RULE16) only enabled bits reach the pin
    assign irq = |(sts_q & msk_q);

    // Receive packer: low lane first, partial word
    // padded with zero bytes at frame end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_q      <= 2'b00;
            word_q      <= RST_WORD;
            wr_valid_q  <= 1'b0;
            wr_data_q   <= RST_WORD;
            stat_pend_q <= 1'b0;
            stat_q      <= 8'h00;
        end else begin
            wr_valid_q <= 1'b0;
            if (rx_byte_valid) begin
                word_q[lane_q*8 +: 8] <= rx_byte;
                lane_q <= lane_q + 2'b01;
                if (lane_q == 2'b11) begin
                    wr_valid_q <= 1'b1;
                    wr_data_q  <= {rx_byte, word_q[23:0]};
                    word_q     <= RST_WORD;
                end
            end else if (rx_end && lane_q != 2'b00) begin
                // (RULE9) flush zero padded word
                wr_valid_q <= 1'b1;
                wr_data_q  <= word_q;
                word_q     <= RST_WORD;
                lane_q     <= 2'b00;
            end else if (stat_pend_q) begin
                // (RULE8) status byte in own word
                wr_valid_q  <= 1'b1;
                wr_data_q   <= {24'h00_0000, stat_q};
                stat_pend_q <= 1'b0;
            end
            if (rx_end && xcv_q.repeated_receive) begin
                stat_pend_q <= 1'b1;
                stat_q      <= rx_status;
            end
        end
    end
    assign mem_wr_valid = wr_valid_q;
    assign mem_wr_data  = wr_data_q;

    // (RULE8) rearm pulse after each reception
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rearm_q <= 1'b0;
        end else begin
            rearm_q <= rx_end & xcv_q.repeated_receive;
        end
    end
    assign rx_rearm = rearm_q;

    // Read data captured in setup so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RST_WORD;
        end else if (rd_setup) begin
            prdata_q <= RST_WORD;
            if (tgr_hit(paddr, IDX_XCV_CTRL))
                prdata_q[9:0] <= xcv_q;
            if (tgr_hit(paddr, IDX_PAD_DRIVE))
                prdata_q <= pad_q;
            if (tgr_hit(paddr, IDX_AUX_LEVELS))
                prdata_q[AUX_N-1:0] <= lvl_q;
            if (tgr_hit(paddr, IDX_CNT_A_STAT))
                prdata_q[CNT_RUN_BIT:0] <= cnt_sts[0];
            if (tgr_hit(paddr, IDX_CNT_B_STAT))
                prdata_q[CNT_RUN_BIT:0] <= cnt_sts[1];
            if (tgr_hit(paddr, IDX_CNT_C_STAT))
                prdata_q[CNT_RUN_BIT:0] <= cnt_sts[2];
            if (tgr_hit(paddr, IDX_CNT_A_LOAD))
                prdata_q[CNT_W-1:0] <= load_a_q;
            if (tgr_hit(paddr, IDX_CNT_B_LOAD))
                prdata_q[CNT_W-1:0] <= load_b_q;
            if (tgr_hit(paddr, IDX_IRQ_STAT))
                prdata_q[IRQ_W-1:0] <= sts_q;
            if (tgr_hit(paddr, IDX_IRQ_MASK))
                prdata_q[IRQ_W-1:0] <= msk_q;
        end
    end
    assign prdata = prdata_q;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_zero_mask;
        xcv_q.state_mask == 6'h00 |-> !state_evt;
    endproperty
    a_zero_mask: assert property (p_zero_mask) // (RULE2)
        else $error("event with empty mask");

    property p_evt_fires;
        entered && xcv_q.state_mask[xcv_state] && msk_q[IRQ_STATE_BIT]
        |=> sts_q[IRQ_STATE_BIT] && irq;
    endproperty
    a_evt_fires: assert property (p_evt_fires) // (RULE1)
        else $error("selected state entry lost");

    property p_skip;
        xcv_q.skip_send |-> !tx_go;
    endproperty
    a_skip: assert property (p_skip) // (RULE4)
        else $error("transmit started while suppressed");

    property p_skip_clr;
        entered && xcv_state == TGR_AWAIT_REPLY |=> !xcv_q.skip_send;
    endproperty
    a_skip_clr: assert property (p_skip_clr) // (RULE5)
        else $error("suppress bit not cleared");

    property p_hold;
        tx_byte_done && xcv_q.per_byte_framing
        ##1 !tx_trigger[*2] |-> encoder_hold;
    endproperty
    a_hold: assert property (p_hold) // (RULE7)
        else $error("coder not paused");

    property p_rearm;
        rx_end && xcv_q.repeated_receive |=> rx_rearm;
    endproperty
    a_rearm: assert property (p_rearm) // (RULE8)
        else $error("receiver not rearmed");

    property p_pad;
        rx_end && !rx_byte_valid && lane_q != 2'b00
        |=> mem_wr_valid
            && (mem_wr_data >> {$past(lane_q), 3'b000}) == 32'h0;
    endproperty
    a_pad: assert property (p_pad) // (RULE9)
        else $error("partial word not zero padded");

    property p_clear;
        wr_en && tgr_hit(paddr, IDX_IRQ_STAT)
        && pwdata[IRQ_STATE_BIT] && !state_evt
        |=> !sts_q[IRQ_STATE_BIT];
    endproperty
    a_clear: assert property (p_clear) // (RULE17)
        else $error("state event not cleared");

    property p_run;
        cnt_start[0] |=> cnt_sts[0].counter_active
        && cnt_sts[0].counter_live_value == $past(load_a_q);
    endproperty
    a_run: assert property (p_run) // (RULE13)
        else $error("counter did not start");

    property p_count;
        cnt_run[1] && cnt_val[1] != '0 && !cnt_start[1] && !cnt_stop[1]
        |=> cnt_val[1] == $past(cnt_val[1]) - 20'h00001;
    endproperty
    a_count: assert property (p_count) // (RULE14)
        else $error("counter value not tracking");

    c_evt:    cover property (state_evt ##1 irq);
    c_stat:   cover property (rx_end && xcv_q.repeated_receive
                              ##[1:3] mem_wr_valid);
    c_expire: cover property (cnt_exp[0]);

endmodule : tgr_regs

// [tgr_host.sv]
`timescale 1ns/1ps
module tgr_host (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; released address and data show inverted values, never stale ones
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e, output logic to);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        to = 1'b1;
        r = 32'h0;
        e = 1'b0;
        // Bounded wait for the slave answer
        for (n = 0; n < 16 && to; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                to = 1'b0;
                r = prdata;
                e = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : tgr_host

// [tb.sv]
`timescale 1ns/1ps
module tb;
    import tgr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, rx_byte, rx_status;
    logic [31:0] pwdata, prdata, mem_wr_data, rv, d;
    tgr_state_t  xcv_state;
    logic        send_request, guard_expired, tx_trigger, tx_byte_done;
    logic        tx_go, encoder_hold, per_byte_framing, initiator, irq;
    logic        rx_byte_valid, rx_end, rx_rearm, mem_wr_valid, ev, tv;
    logic [2:0]  cnt_start, cnt_stop;
    logic [19:0] cnt_c_preload, pre;
    logic [6:0]  aux_output_drive_en, aux_output_level;
    logic [47:0] bs;
    logic [31:0] words[$];
    int          err_total, check_count, rearms, i;

    tgr_regs u_tgr_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xcv_state(xcv_state),
        .send_request(send_request), .guard_expired(guard_expired),
        .tx_trigger(tx_trigger), .tx_byte_done(tx_byte_done),
        .tx_go(tx_go), .encoder_hold(encoder_hold),
        .per_byte_framing(per_byte_framing), .initiator(initiator),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_end(rx_end), .rx_status(rx_status), .rx_rearm(rx_rearm),
        .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
        .cnt_start(cnt_start), .cnt_stop(cnt_stop),
        .cnt_c_preload(cnt_c_preload),
        .aux_output_drive_en(aux_output_drive_en),
        .aux_output_level(aux_output_level), .irq(irq));

    tgr_host u_tgr_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // Free-running clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Collect buffer writes and rearm pulses
    always @(posedge pclk) begin
        if (mem_wr_valid === 1'b1) begin
            words.push_back(mem_wr_data);
        end
        if (rx_rearm === 1'b1) begin
            rearms++;
        end
    end

    function automatic logic [7:0] ad(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction : ad

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : chk

    // A bus timeout ends the run as a failure
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        u_tgr_host.xfer(w, a, wd, rv, ev, tv);
        if (tv) begin
            err_total++;
            summarize();
        end
    endtask : acc

    task automatic rchk(input logic [5:0] idx, input logic [31:0] e);
        acc(1'b0, ad(idx), 32'h0);
        chk(rv, e);
    endtask : rchk

    // Hang guard
    initial begin
        repeat (50000) @(posedge pclk);
        err_total++;
        summarize();
    end

    initial begin
        {presetn, send_request, guard_expired, tx_trigger} = 4'h0;
        {tx_byte_done, rx_byte_valid, rx_end} = 3'h0;
        {rx_byte, rx_status, cnt_start, cnt_stop} = 22'h0;
        cnt_c_preload = 20'h0;
        xcv_state = TGR_IDLE;
        void'($urandom(32'h208e));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, read-only status, unmapped place
        for (i = 4; i < 18; i++) begin
            if (i != 6 && i < 13 || i > 15) begin
                rchk(6'(i), 32'h0);
            end
        end
        acc(1'b1, ad(IDX_CNT_A_STAT), 32'hffff_ffff);
        rchk(IDX_CNT_A_STAT, 32'h0);
        acc(1'b0, 8'h3c, 32'h0);
        chk(rv, 32'h0);
        chk(ev, 1'b1);
        // Output enables and levels
        d = $urandom;
        acc(1'b1, ad(IDX_PAD_DRIVE), d);
        rchk(IDX_PAD_DRIVE, d & 32'hff);
        chk(aux_output_drive_en, d[6:0]);
        d = $urandom;
        acc(1'b1, ad(IDX_AUX_LEVELS), d);
        rchk(IDX_AUX_LEVELS, d & 32'h7f);
        chk(aux_output_level, d[6:0]);
        for (i = 0; i < 6; i++) begin
            xcv_state <= tgr_state_t'(3'((i + 1) % 6));
            acc(1'b1, ad(IDX_IRQ_MASK), i[0] ? 32'h20 : 32'h0);
            rchk(IDX_IRQ_STAT, 32'h0);
            acc(1'b1, ad(IDX_XCV_CTRL), (32'h1 << (4 + i)) | i[0]);
            xcv_state <= tgr_state_t'(3'(i));
            repeat (2) @(posedge pclk);
            // Control write lands on the access edge, look after it
            chk(initiator, i[0]);
            chk(irq, i[0]);
            rchk(IDX_IRQ_STAT, 32'h20);
            acc(1'b1, ad(IDX_IRQ_STAT), 32'h20);
            rchk(IDX_IRQ_STAT, 32'h0);
            chk(irq, 1'b0);
            acc(1'b1, ad(IDX_XCV_CTRL), 32'h0);
        end
        send_request <= 1'b1;
        guard_expired <= 1'b1;
        acc(1'b1, ad(IDX_XCV_CTRL), 32'h8);
        @(negedge pclk);
        chk(tx_go, 1'b0);
        @(posedge pclk);
        xcv_state <= TGR_AWAIT_REPLY;
        repeat (2) @(negedge pclk);
        chk(tx_go, 1'b1);
        rchk(IDX_XCV_CTRL, 32'h0);
        acc(1'b1, ad(IDX_XCV_CTRL), 32'h4);
        tx_byte_done <= 1'b1;
        @(posedge pclk);
        tx_byte_done <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(per_byte_framing, 1'b1);
        chk(encoder_hold, 1'b1);
        tx_trigger <= 1'b1;
        @(posedge pclk);
        tx_trigger <= 1'b0;
        @(negedge pclk);
        chk(encoder_hold, 1'b0);
        acc(1'b1, ad(IDX_XCV_CTRL), 32'h2);
        bs = 48'({$urandom, $urandom});
        d = $urandom;
        words.delete();
        for (i = 0; i < 6; i++) begin
            rx_byte_valid <= 1'b1;
            rx_byte <= bs[8*i+:8];
            @(posedge pclk);
        end
        rx_byte_valid <= 1'b0;
        rx_end <= 1'b1;
        rx_status <= d[7:0];
        @(posedge pclk);
        rx_end <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(words.size(), 3);
        chk(rearms, 1);
        if (words.size() == 3) begin
            chk(words[0], bs[31:0]);
            chk(words[1], {16'h0, bs[47:32]});
            chk(words[2], {24'h0, d[7:0]});
        end
        pre = 20'(3 + $urandom % 16);
        acc(1'b1, ad(IDX_CNT_A_LOAD), {12'hfff, pre});
        rchk(IDX_CNT_A_LOAD, {12'h0, pre});
        acc(1'b1, ad(IDX_CNT_B_LOAD), 32'hffff_ffff);
        rchk(IDX_CNT_B_LOAD, 32'hfffff);
        cnt_c_preload <= pre;
        acc(1'b1, ad(IDX_IRQ_MASK), 32'h2800);
        cnt_start <= 3'b111;
        @(posedge pclk);
        cnt_start <= 3'b000;
        acc(1'b0, ad(IDX_CNT_A_STAT), 32'h0);
        chk(rv[20], 1'b1);
        chk(rv[19:0] <= pre && rv[19:0] + 3 > pre, 1'b1);
        cnt_stop <= 3'b010;
        @(posedge pclk);
        cnt_stop <= 3'b000;
        repeat (30) @(posedge pclk);
        rchk(IDX_CNT_A_STAT, 32'h0);
        rchk(IDX_CNT_C_STAT, 32'h0);
        acc(1'b0, ad(IDX_CNT_B_STAT), 32'h0);
        chk(rv[20], 1'b0);
        rchk(IDX_IRQ_STAT, 32'h2800);
        chk(irq, 1'b1);
        // Second reset in mid-run
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        chk({aux_output_drive_en, aux_output_level}, 14'h0);
        chk(irq, 1'b0);
        rchk(IDX_IRQ_MASK, 32'h0);
        rchk(IDX_XCV_CTRL, 32'h0);
        summarize();
    end
endmodule : tb
